// [rtl/pif_defines.svh]
// Register indices, field positions, reset values and constants of the block.
`ifndef PIF_DEFINES_SVH
`define PIF_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PIF_IDX_PERIPH_IRQ_ENABLE_2     6'h11
`define PIF_IDX_PERIPH_IRQ_REQUEST_1     6'h16
`define PIF_IDX_CTRL     6'h20
`define PIF_IDX_T1PER    6'h21
`define PIF_IDX_T2PER    6'h22
`define PIF_IDX_T3PERL   6'h23
`define PIF_IDX_T3PERH   6'h24
`define PIF_IDX_PORTREF  6'h25
`define PIF_IDX_ISTAT    6'h26
`define PIF_IDX_IMASK    6'h27

// ****************************************************************
// Field positions and masks
// ****************************************************************
`define PIF_PERIPH_IRQ_ENABLE_2_MASK    8'hEF
`define PIF_CTRL_GID     0
`define PIF_CTRL_C1P3    1
`define PIF_CTRL_T16     2

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define PIF_PERIPH_IRQ_ENABLE_2_RST     8'h00
`define PIF_CTRL_RST     3'h1
`define PIF_PER_RST      8'hFF
`define PIF_TX_RST       1'h1
`define PIF_RX_RST       1'h0
`define PIF_T3_MAX       16'hFFFF

`endif

// [rtl/pif_pkg.sv]
// Types shared by the peripheral interrupt flag and enable block.
package pif_pkg;
	typedef logic [7:0]  pif_byte_t;
	typedef logic [31:0] pif_word_t;
	typedef logic [5:0]  pif_ev_t;
endpackage : pif_pkg

// [rtl/pif_sync.sv]
// Two-stage synchroniser for the port and capture pins.
module pif_sync (
	input  wire logic       ref_clk, // Core clock.
	input  wire logic       rst_n,   // Synchronous reset, active low.
	input  wire logic [9:0] din,     // Asynchronous pin levels.
	output logic      [9:0] dout     // Synchronised levels.
);
	logic [9:0] meta_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_q <= 10'h000;
			dout   <= 10'h000;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : pif_sync

// [rtl/pif_irq_ctrl.sv]
// Peripheral interrupt request and enable registers with APB access.
//
// Added by the designer: the APB register port.
`include "pif_defines.svh"

module pif_irq_ctrl (
	input  wire logic             ref_clk,     // Core clock, 250 MHz.
	input  wire logic             rst_n,       // Synchronous reset, active low.
	input  wire logic             psel,        // APB select.
	input  wire logic             penable,     // APB access phase.
	input  wire logic             pwrite,      // APB write.
	input  wire logic [7:0]       paddr,       // APB byte address.
	input  wire pif_pkg::pif_word_t pwdata,    // APB write data.
	input  wire logic [3:0]       pstrb,       // APB byte strobes.
	output pif_pkg::pif_word_t    prdata,      // APB read data.
	output logic                  pready,      // APB ready.
	output logic                  pslverr,     // APB error, unmapped address.
	input  wire pif_pkg::pif_byte_t portPins,  // Monitored port pins.
	input  wire logic             cap1Pin,     // Capture one pin.
	input  wire logic             cap2Pin,     // Capture two pin.
	input  wire pif_pkg::pif_byte_t tmr1Count, // Timer one count.
	input  wire pif_pkg::pif_byte_t tmr2Count, // Timer two count.
	input  wire logic [15:0]      tmr3Count,   // Timer three count.
	input  wire logic             usart1TxEmpty, // USART1 transmit buffer empty.
	input  wire logic             usart1RxFull,  // USART1 receive buffer full.
	input  wire pif_pkg::pif_byte_t pie1Enables, // First enable register.
	input  wire pif_pkg::pif_byte_t pir2Flags,   // Second request register.
	output pif_pkg::pif_byte_t    pieEnable2,  // Second enable register.
	output pif_pkg::pif_byte_t    pirRequest1, // First request register.
	output logic                  periphPendingFlag, // Peripheral pending.
	output logic                  globalIrqDisable,  // Global disable bit.
	output logic                  capture1Period3Select, // Timer three mode.
	output logic                  timer1WidthSelect,     // Timer one width.
	output logic                  irq          // Block interrupt, active high.
);
	import pif_pkg::*;

	// ****************************************************************
	// Storage
	// ****************************************************************
	pif_byte_t  periph_irq_enable_2_q;
	logic [5:0] pir1Sw_q;
	logic       txFlag_q;
	logic       rxFlag_q;
	logic [2:0] ctrl_q;
	pif_byte_t  t1Per_q;
	pif_byte_t  t2Per_q;
	pif_byte_t  t3PerL_q;
	pif_byte_t  t3PerH_q;
	pif_byte_t  portRef_q;
	pif_ev_t    stat_q;
	pif_ev_t    mask_q;
	logic       irq_q;
	logic       pend_q;
	pif_byte_t  t1Prev_q;
	pif_byte_t  t2Prev_q;
	logic [15:0] t3Prev_q;
	logic [1:0] capPrev_q;
	pif_word_t  prdata_q;
	logic       pready_q;
	logic       pslverr_q;
	logic [9:0] syncd;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// True when a count has rolled to zero from the compare value.
	function automatic logic rolled(input logic [15:0] prev,
			input logic [15:0] now, input logic [15:0] per);
		rolled = (prev == per) && (now == 16'h0000);
	endfunction : rolled

	function automatic logic isReg(input logic [5:0] a, input logic [5:0] r);
		isReg = (a == r);
	endfunction : isReg

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	pif_sync u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.din     ({portPins, cap2Pin, cap1Pin}),
		.dout    (syncd)
	);

	wire pif_byte_t portNow = syncd[9:2];
	wire [1:0]      capNow  = syncd[1:0];

	// ****************************************************************
	// APB decode
	// ****************************************************************
	wire       acc     = psel && penable;
	wire [5:0] idx     = paddr[7:2];
	wire       aligned = (paddr[1:0] == 2'h0);
	wire       mapped  = aligned && (isReg(idx, `PIF_IDX_PERIPH_IRQ_ENABLE_2) ||
			isReg(idx, `PIF_IDX_PERIPH_IRQ_REQUEST_1) || isReg(idx, `PIF_IDX_CTRL) ||
			isReg(idx, `PIF_IDX_T1PER) || isReg(idx, `PIF_IDX_T2PER) ||
			isReg(idx, `PIF_IDX_T3PERL) || isReg(idx, `PIF_IDX_T3PERH) ||
			isReg(idx, `PIF_IDX_PORTREF) || isReg(idx, `PIF_IDX_ISTAT) ||
			isReg(idx, `PIF_IDX_IMASK));
	// Writes take effect only at the edge where the access completes.
	wire       wrDone  = acc && pready_q && pwrite && aligned && pstrb[0];
	wire       rdDone  = acc && pready_q && !pwrite && aligned;
	wire       wrPie2  = wrDone && isReg(idx, `PIF_IDX_PERIPH_IRQ_ENABLE_2);
	wire       wrPir1  = wrDone && isReg(idx, `PIF_IDX_PERIPH_IRQ_REQUEST_1);
	wire       wrCtrl  = wrDone && isReg(idx, `PIF_IDX_CTRL);
	wire       wrT1    = wrDone && isReg(idx, `PIF_IDX_T1PER);
	wire       wrT2    = wrDone && isReg(idx, `PIF_IDX_T2PER);
	wire       wrT3L   = wrDone && isReg(idx, `PIF_IDX_T3PERL);
	wire       wrT3H   = wrDone && isReg(idx, `PIF_IDX_T3PERH);
	wire       wrStat  = wrDone && isReg(idx, `PIF_IDX_ISTAT);
	wire       wrMask  = wrDone && isReg(idx, `PIF_IDX_IMASK);
	// Reading the port snapshot re-arms the change detector.
	wire       rdPort  = rdDone && isReg(idx, `PIF_IDX_PORTREF);

	wire pif_byte_t pir1Full = {pir1Sw_q, txFlag_q, rxFlag_q};
	wire pif_byte_t rdMux =
		isReg(idx, `PIF_IDX_PERIPH_IRQ_ENABLE_2)    ? periph_irq_enable_2_q :
		isReg(idx, `PIF_IDX_PERIPH_IRQ_REQUEST_1)    ? pir1Full :
		isReg(idx, `PIF_IDX_CTRL)    ? {5'h00, ctrl_q} :
		isReg(idx, `PIF_IDX_T1PER)   ? t1Per_q :
		isReg(idx, `PIF_IDX_T2PER)   ? t2Per_q :
		isReg(idx, `PIF_IDX_T3PERL)  ? t3PerL_q :
		isReg(idx, `PIF_IDX_T3PERH)  ? t3PerH_q :
		isReg(idx, `PIF_IDX_PORTREF) ? portNow :
		isReg(idx, `PIF_IDX_ISTAT)   ? {2'h0, stat_q} :
		isReg(idx, `PIF_IDX_IMASK)   ? {2'h0, mask_q} : 8'h00;

	// ****************************************************************
	// Event detection
	// ****************************************************************
	wire sel13 = ctrl_q[`PIF_CTRL_C1P3];
	wire t16   = ctrl_q[`PIF_CTRL_T16];
	wire portEv = (portNow != portRef_q);
	wire t3OvEv = sel13 && rolled(t3Prev_q, tmr3Count, `PIF_T3_MAX);
	wire t3PrEv = !sel13 && rolled(t3Prev_q, tmr3Count, {t3PerH_q, t3PerL_q});
	wire t3Ev   = t3OvEv || t3PrEv;
	wire t2Ev   = !t16 && rolled({8'h00, t2Prev_q}, {8'h00, tmr2Count},
			{8'h00, t2Per_q});
	wire t1Ev8  = !t16 && rolled({8'h00, t1Prev_q}, {8'h00, tmr1Count},
			{8'h00, t1Per_q});
	wire t1Ev16 = t16 && rolled({t2Prev_q, t1Prev_q}, {tmr2Count, tmr1Count},
			{t2Per_q, t1Per_q});
	wire t1Ev   = t1Ev8 || t1Ev16;
	wire cap2Ev = capNow[1] && !capPrev_q[1];
	wire cap1Ev = capNow[0] && !capPrev_q[0];
	wire pif_ev_t ev = {portEv, t3Ev, t2Ev, t1Ev, cap2Ev, cap1Ev};

	// ****************************************************************
	// Next values
	// ****************************************************************
	// set wins, enables ignored
	wire [5:0] pir1Sw_d = (wrPir1 ? pwdata[7:2] : pir1Sw_q) | ev;
	wire pif_byte_t periph_irq_enable_2_d = wrPie2 ? (pwdata[7:0] & `PIF_PERIPH_IRQ_ENABLE_2_MASK) : periph_irq_enable_2_q;
	wire pif_ev_t stat_d = (wrStat ? (stat_q & ~pwdata[5:0]) : stat_q) | ev;
	wire pend_d = |(pir1Full & pie1Enables) || |(pir2Flags & periph_irq_enable_2_q);

	// ****************************************************************
	// APB slave, one wait state
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= acc && !pready_q;
			pslverr_q <= acc && !pready_q && !mapped;
			prdata_q  <= (acc && !pready_q && !pwrite) ? {24'h000000, rdMux} : 32'h0;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			periph_irq_enable_2_q   <= `PIF_PERIPH_IRQ_ENABLE_2_RST;
			pir1Sw_q <= 6'h00;
			txFlag_q <= `PIF_TX_RST;
			rxFlag_q <= `PIF_RX_RST;
			ctrl_q   <= `PIF_CTRL_RST;
			t1Per_q  <= `PIF_PER_RST;
			t2Per_q  <= `PIF_PER_RST;
			t3PerL_q <= `PIF_PER_RST;
			t3PerH_q <= `PIF_PER_RST;
			stat_q   <= 6'h00;
			mask_q   <= 6'h00;
			irq_q    <= 1'b0;
			pend_q   <= 1'b0;
		end else begin
			periph_irq_enable_2_q   <= periph_irq_enable_2_d;
			pir1Sw_q <= pir1Sw_d;
			txFlag_q <= usart1TxEmpty;
			rxFlag_q <= usart1RxFull;
			ctrl_q   <= wrCtrl ? pwdata[2:0] : ctrl_q;
			t1Per_q  <= wrT1 ? pwdata[7:0] : t1Per_q;
			t2Per_q  <= wrT2 ? pwdata[7:0] : t2Per_q;
			t3PerL_q <= wrT3L ? pwdata[7:0] : t3PerL_q;
			t3PerH_q <= wrT3H ? pwdata[7:0] : t3PerH_q;
			stat_q   <= stat_d;
			mask_q   <= wrMask ? pwdata[5:0] : mask_q;
			// The interrupt output is one register stage behind the masked status.
			irq_q    <= |(stat_q & mask_q);
			pend_q   <= pend_d;
		end
	end

	// ****************************************************************
	// Source history
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			portRef_q <= 8'h00;
			t1Prev_q  <= 8'h00;
			t2Prev_q  <= 8'h00;
			t3Prev_q  <= 16'h0000;
			capPrev_q <= 2'h0;
		end else begin
			portRef_q <= rdPort ? portNow : portRef_q;
			t1Prev_q  <= tmr1Count;
			t2Prev_q  <= tmr2Count;
			t3Prev_q  <= tmr3Count;
			capPrev_q <= capNow;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata                = prdata_q;
	assign pready                = pready_q;
	assign pslverr               = pslverr_q;
	assign pieEnable2            = periph_irq_enable_2_q;
	assign pirRequest1           = pir1Full;
	assign periphPendingFlag     = pend_q;
	assign globalIrqDisable      = ctrl_q[`PIF_CTRL_GID];
	assign capture1Period3Select = ctrl_q[`PIF_CTRL_C1P3];
	assign timer1WidthSelect     = ctrl_q[`PIF_CTRL_T16];
	assign irq                   = irq_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_periph_irq_enable_2_write_mask: assert property (
		wrPie2 |=> periph_irq_enable_2_q == ($past(pwdata[7:0]) & 8'hEF))
		else $error("enable register two write not stored as masked");
	a_port_change_set: assert property (
		portEv |=> pir1Sw_q[5])
		else $error("port change flag not set");
	a_t3_overflow: assert property (
		(sel13 && t3Prev_q == 16'hFFFF && tmr3Count == 16'h0000) |=> pir1Sw_q[4])
		else $error("timer three overflow flag not set");
	a_t3_period: assert property (
		(!sel13 && t3Prev_q == {t3PerH_q, t3PerL_q} && tmr3Count == 16'h0000)
		|=> pir1Sw_q[4])
		else $error("timer three period flag not set");
	a_t2_period: assert property (
		(!t16 && t2Prev_q == t2Per_q && tmr2Count == 8'h00) |=> pir1Sw_q[3])
		else $error("timer two flag not set");
	a_t1_eight: assert property (
		(!t16 && t1Prev_q == t1Per_q && tmr1Count == 8'h00) |=> pir1Sw_q[2])
		else $error("timer one eight-bit flag not set");
	a_t1_sixteen: assert property (
		(t16 && {t2Prev_q, t1Prev_q} == {t2Per_q, t1Per_q} &&
		{tmr2Count, tmr1Count} == 16'h0000) |=> pir1Sw_q[2])
		else $error("timer one sixteen-bit flag not set");
	a_cap2_set: assert property (
		(capNow[1] && !capPrev_q[1]) |=> pirRequest1[3])
		else $error("capture two flag not set");
	a_cap1_set: assert property (
		(capNow[0] && !capPrev_q[0]) |=> pirRequest1[2])
		else $error("capture one flag not set");
	a_tx_mirror: assert property (
		##1 pirRequest1[1] == $past(usart1TxEmpty))
		else $error("transmit flag does not follow buffer");
	a_rx_mirror: assert property (
		##1 pirRequest1[0] == $past(usart1RxFull))
		else $error("receive flag does not follow buffer");
	a_set_over_clear: assert property (
		(wrPir1 && pwdata[2] == 1'b0 && cap1Ev) |=> pirRequest1[2])
		else $error("clear beat a simultaneous event");
	a_pending_or: assert property (
		##1 periphPendingFlag ==
		($past(|(pirRequest1 & pie1Enables)) || $past(|(pir2Flags & pieEnable2))))
		else $error("pending flag not OR of enabled requests");
	a_reset_values: assert property (
		$past(rst_n) == 1'b0 |-> (globalIrqDisable && pieEnable2 == 8'h00 &&
		pirRequest1[7:2] == 6'h00))
		else $error("wrong values after reset");
	a_irq_level: assert property (
		|(stat_q & mask_q) |=> irq)
		else $error("interrupt output not raised for a masked-in status bit");
	a_irq_quiet: assert property (
		!(|(stat_q & mask_q)) |=> !irq)
		else $error("interrupt output high with no masked-in status bit");
	a_status_clear: assert property (
		(wrStat && ev == 6'h00) |=> (stat_q & $past(pwdata[5:0])) == 6'h00)
		else $error("status bits not cleared by a write of one");
	a_periph_irq_enable_2_bit_four: assert property (pieEnable2[4] == 1'b0)
		else $error("unused enable bit reads as one");
	a_t2_paired_quiet: assert property (
		(t16 && !wrPir1 && !pir1Sw_q[3]) |=> !pir1Sw_q[3])
		else $error("timer two flag set in sixteen-bit mode");
	a_global_hold: assert property (
		!wrCtrl |=> $stable(globalIrqDisable))
		else $error("global disable bit changed without a write");
endmodule : pif_irq_ctrl

// [bench/pif_peer.sv]
// Timer counts that the peripheral side presents to the flag block.
module pif_peer (
	input  wire logic          ref_clk,   // Core clock.
	input  wire logic          run,       // Count while high, hold zero while low; load3 still loads timer three while low.
	input  wire logic          pair,      // Timers one and two count as one.
	input  wire logic [15:0]   per12,     // Wrap values, timer two in the high byte.
	input  wire logic [15:0]   per3,      // Timer three wrap value.
	input  wire logic          load3,     // Load timer three.
	input  wire logic [15:0]   val3,      // Timer three load value.
	output pif_pkg::pif_byte_t tmr1Count, // Timer one count.
	output pif_pkg::pif_byte_t tmr2Count, // Timer two count.
	output logic [15:0]        tmr3Count  // Timer three count.
);
	import pif_pkg::*;
	logic [15:0] cnt12;
	assign cnt12 = {tmr2Count, tmr1Count};
	always @(posedge ref_clk) begin
		if (load3) begin
			tmr3Count <= val3;
		end else if (!run) begin
			tmr3Count <= 16'h0000;
		end else begin
			tmr3Count <= (tmr3Count == per3) ? 16'h0000 : tmr3Count + 16'h0001;
		end
		if (!run) begin
			{tmr2Count, tmr1Count} <= 16'h0000;
		end else if (pair) begin
			{tmr2Count, tmr1Count} <= (cnt12 == per12) ? 16'h0000 : cnt12 + 16'h0001;
		end else begin
			tmr1Count <= (tmr1Count == per12[7:0]) ? 8'h00 : tmr1Count + 8'h01;
			tmr2Count <= (tmr2Count == per12[15:8]) ? 8'h00 : tmr2Count + 8'h01;
		end
	end
endmodule : pif_peer

// [bench/tb.sv]
// Self-checking bench for the peripheral interrupt flag and enable block.
`include "pif_defines.svh"
module tb;
	import pif_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [3:0] pstrb = 4'hF;
	pif_word_t pwdata = 32'h0, prdata;
	logic pready, pslverr, cap1Pin = 0, cap2Pin = 0, txE = 1, rxF = 0;
	pif_byte_t portPins = 8'h00, pie1 = 8'h00, pir2 = 8'h00, t1, t2, pe2, pr1;
	logic [15:0] t3, per12 = 16'h0, per3 = 16'hFFFF, val3 = 16'h0;
	logic pend, gid, c1p3, t16, irq, run = 0, pair = 0, load3 = 0;
	int mismatches = 0, checksDone = 0;
	always #2 ref_clk = ~ref_clk;
	pif_irq_ctrl i_pif_irq_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.portPins(portPins), .cap1Pin(cap1Pin), .cap2Pin(cap2Pin), .tmr1Count(t1),
		.tmr2Count(t2), .tmr3Count(t3), .usart1TxEmpty(txE), .usart1RxFull(rxF),
		.pie1Enables(pie1), .pir2Flags(pir2), .pieEnable2(pe2), .pirRequest1(pr1),
		.periphPendingFlag(pend), .globalIrqDisable(gid),
		.capture1Period3Select(c1p3), .timer1WidthSelect(t16), .irq(irq));
	pif_peer i_pif_peer (.ref_clk(ref_clk), .run(run), .pair(pair), .per12(per12),
		.per3(per3), .load3(load3), .val3(val3), .tmr1Count(t1), .tmr2Count(t2),
		.tmr3Count(t3));
	task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
		checksDone++;
		if (s !== x) begin
			mismatches++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, s, x);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	task automatic apb(input logic w, input logic [5:0] i, input pif_word_t d,
		output pif_word_t r, output logic e);
		psel <= 1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		// Only the watchdog ends an access that never completes.
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge ref_clk);
	endtask : apb
	task automatic wr(input logic [5:0] i, input pif_word_t d);
		pif_word_t r;
		logic e;
		apb(1, i, d, r, e);
	endtask : wr
	task automatic rd(input logic [5:0] i, input pif_word_t x, input string m);
		pif_word_t r;
		logic e;
		apb(0, i, 32'h0, r, e);
		chk(r, x, m);
	endtask : rd
	task automatic waitFlag(input int b, input int lim, input string m);
		int n;
		n = 0;
		while (pr1[b] !== 1'b1 && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		chk(pr1[b], 1, m);
	endtask : waitFlag
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic tReset();
		pif_word_t r;
		logic e;
		rd(`PIF_IDX_PERIPH_IRQ_ENABLE_2, 32'h00, "enable2 reset");
		rd(`PIF_IDX_PERIPH_IRQ_REQUEST_1, 32'h02, "request1 reset");
		rd(`PIF_IDX_CTRL, 32'h01, "control reset");
		chk(gid, 1, "disable bit");
		apb(0, 6'h3F, 32'h0, r, e);
		chk(e, 1, "unmapped error");
		chk(r, 0, "unmapped reads zero");
		$display("test reset done");
	endtask : tReset
	task automatic tEnable2();
		wr(`PIF_IDX_PERIPH_IRQ_ENABLE_2, 32'hFF);
		rd(`PIF_IDX_PERIPH_IRQ_ENABLE_2, 32'hEF, "enable2 bit4");
		chk(pe2, 8'hEF, "enable2 port");
		pstrb <= 4'hE;
		wr(`PIF_IDX_PERIPH_IRQ_ENABLE_2, 32'h00);
		pstrb <= 4'hF;
		rd(`PIF_IDX_PERIPH_IRQ_ENABLE_2, 32'hEF, "strobe ignored");
		wr(`PIF_IDX_PERIPH_IRQ_ENABLE_2, 32'h00);
		pir2 <= 8'h01;
		wr(`PIF_IDX_PERIPH_IRQ_ENABLE_2, 32'h01);
		@(posedge ref_clk);
		chk(pend, 1, "pending two");
		wr(`PIF_IDX_PERIPH_IRQ_ENABLE_2, 32'h00);
		@(posedge ref_clk);
		chk(pend, 0, "pending off");
		pie1 <= 8'h02;
		wr(`PIF_IDX_PERIPH_IRQ_REQUEST_1, 32'h00);
		chk(pend, 1, "pending one");
		pie1 <= 8'h00;
		$display("test enable2 done");
	endtask : tEnable2
	task automatic tUsartPins();
		txE <= 0;
		rxF <= 1;
		wr(`PIF_IDX_PERIPH_IRQ_REQUEST_1, 32'h03);
		rd(`PIF_IDX_PERIPH_IRQ_REQUEST_1, 32'h01, "usart levels");
		txE <= 1;
		rxF <= 0;
		cap1Pin <= 1;
		waitFlag(2, 10, "capture one");
		cap2Pin <= 1;
		waitFlag(3, 10, "capture two");
		portPins <= 8'h5A;
		waitFlag(7, 10, "port change");
		rd(`PIF_IDX_PORTREF, 32'h5A, "port reference");
		wr(`PIF_IDX_PERIPH_IRQ_REQUEST_1, 32'h00);
		repeat (4) @(posedge ref_clk);
		chk(pr1, 8'h02, "flags cleared");
		cap1Pin <= 0;
		repeat (4) @(posedge ref_clk);
		// event lands on the clearing write
		cap1Pin <= 1;
		wr(`PIF_IDX_PERIPH_IRQ_REQUEST_1, 32'h00);
		chk(pr1, 8'h06, "set beats clear");
		$display("test pins done");
	endtask : tUsartPins
	task automatic tTimers();
		wr(`PIF_IDX_T1PER, 32'h03);
		wr(`PIF_IDX_T2PER, 32'h05);
		per12 <= 16'h0503;
		run <= 1;
		waitFlag(4, 20, "timer one");
		waitFlag(5, 20, "timer two");
		run <= 0;
		wr(`PIF_IDX_IMASK, 32'h0C);
		@(posedge ref_clk);
		chk(irq, 1, "irq raised");
		wr(`PIF_IDX_IMASK, 32'h00);
		@(posedge ref_clk);
		chk(irq, 0, "irq masked");
		wr(`PIF_IDX_ISTAT, 32'h3F);
		rd(`PIF_IDX_ISTAT, 32'h00, "status cleared");
		wr(`PIF_IDX_PERIPH_IRQ_REQUEST_1, 32'h00);
		wr(`PIF_IDX_CTRL, 32'h04);
		chk(t16, 1, "width select");
		chk(gid, 0, "disable cleared");
		pair <= 1;
		run <= 1;
		waitFlag(4, 1400, "paired timer");
		chk(pr1[5], 0, "no timer two");
		run <= 0;
		pair <= 0;
		$display("test timers done");
	endtask : tTimers
	task automatic tTimer3();
		wr(`PIF_IDX_T3PERL, 32'h10);
		wr(`PIF_IDX_T3PERH, 32'h00);
		wr(`PIF_IDX_PERIPH_IRQ_REQUEST_1, 32'h00);
		wr(`PIF_IDX_CTRL, 32'h02);
		chk(c1p3, 1, "capture select");
		val3 <= 16'hFFF0;
		load3 <= 1;
		@(posedge ref_clk);
		load3 <= 0;
		run <= 1;
		waitFlag(6, 40, "timer three overflow");
		run <= 0;
		wr(`PIF_IDX_CTRL, 32'h00);
		wr(`PIF_IDX_PERIPH_IRQ_REQUEST_1, 32'h00);
		load3 <= 1;
		@(posedge ref_clk);
		load3 <= 0;
		run <= 1;
		repeat (40) @(posedge ref_clk);
		chk(pr1[6], 0, "no overflow flag");
		run <= 0;
		per3 <= 16'h0010;
		@(posedge ref_clk);
		run <= 1;
		waitFlag(6, 40, "timer three period");
		run <= 0;
		$display("test timer3 done");
	endtask : tTimer3
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1;
		@(posedge ref_clk);
		tReset();
		tEnable2();
		tUsartPins();
		tTimers();
		tTimer3();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		give_verdict();
	end
endmodule : tb
